// ### verilog/tmr_defs.vh
// Contract
// - Output-mode zero makes a compare match leave the output state alone.
// - New output mode acts at next match; force strobe acts at once in non-PWM.
// - Waveform mode sets counting; output mode sets polarity or set/clear/toggle.
// - Normal mode counts up only, wrapping 0xFF to 0x00; writes allowed anytime.
// - Normal mode sets overflow flag as counter becomes zero; hardware never clears.
// - Clear-on-compare mode clears the counter when it matches the compare value.
// - Clear-on-compare compare value unbuffered; low writes make counter wrap first.
// - Clear-on-compare with output mode 1 toggles the output on every match.
// - Clear-on-compare sets overflow flag when counter goes from maximum to zero.
// - Fast PWM counts zero to 0xFF then clears next tick, 256 tick period.
// - Fast PWM mode 2 clears on match, sets at wrap; mode 3 inverse.
// - Fast PWM sets the overflow flag each time the counter reaches maximum.
// - Fast PWM compare zero gives one-tick spike; compare maximum gives constant level.
// - Fast PWM output mode 1 toggles on match; compare stays double buffered.
// - Phase correct counts up to maximum, holds one tick, counts down, repeats.
// - Phase correct mode 2 clears on up match, sets on down match; 3 inverts.
// - Phase correct sets the overflow flag each time the counter reaches zero.
// - Phase correct compare zero gives constant low, maximum constant high; inverted opposite.
// - Phase correct output changes at zero without match when the up match was missed.
// - Output state reaches the pin only when pin direction is output.
// - Clock select zero stops counting; software write beats clear or count.
// - A software counter write blocks compare flag and output matches in the next timer tick; the CTC clear still happens.
// - Match sets compare flag at next tick; software clears it by writing one.
// - PWM modes double buffer the compare value; non-PWM writes act directly.
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH

// register byte offsets
`define TMR_ADDR_CTRL 12'h000
`define TMR_ADDR_COUNT 12'h004
`define TMR_ADDR_CMP 12'h008
`define TMR_ADDR_FLAGS 12'h00C

// control register fields
`define TMR_CTRL_WMODE_LO 0
`define TMR_CTRL_OMODE_LO 2
`define TMR_CTRL_CSEL_LO 4
`define TMR_CTRL_FORCE 7
`define TMR_CTRL_PINDIR 8
`define TMR_CTRL_RST 9'h000

// flag register fields
`define TMR_FLAG_OVF 0
`define TMR_FLAG_CMP 1

// waveform modes
`define TMR_WM_NORMAL 2'h0
`define TMR_WM_PHASE 2'h1
`define TMR_WM_CTC 2'h2
`define TMR_WM_FAST 2'h3

// output modes
`define TMR_OM_OFF 2'h0
`define TMR_OM_TOGGLE 2'h1
`define TMR_OM_CLEAR 2'h2
`define TMR_OM_SET 2'h3

// counter extremes
`define TMR_MAX 8'hFF
`define TMR_BOTTOM 8'h00

// prescaler division masks
`define TMR_DIV8_MASK 10'h007
`define TMR_DIV64_MASK 10'h03F
`define TMR_DIV256_MASK 10'h0FF
`define TMR_DIV1024_MASK 10'h3FF

`endif

// ### verilog/tmr_prescale.v
`include "tmr_defs.vh"
`default_nettype none

module tmr_prescale (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire [2:0] clock_select_field,
    input wire ext_clk_pin,
    output reg timer_tick
);
    reg [9:0] div_q;
    reg ext_prev_q;

    // free running divider; the four divided selections share it, so switching is cheap but unaligned
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 10'h000;
            ext_prev_q <= 1'b0;
        end else if (clk_en) begin
            div_q <= div_q + 10'h001;
            ext_prev_q <= ext_clk_pin;
        end
    end

    // tick selection; select zero yields no tick and stops the counter
    always @* begin
        case (clock_select_field)
            3'h1: timer_tick = 1'b1;
            3'h2: timer_tick = (div_q & `TMR_DIV8_MASK) == `TMR_DIV8_MASK;
            3'h3: timer_tick = (div_q & `TMR_DIV64_MASK) == `TMR_DIV64_MASK;
            3'h4: timer_tick = (div_q & `TMR_DIV256_MASK) == `TMR_DIV256_MASK;
            3'h5: timer_tick = (div_q & `TMR_DIV1024_MASK) == `TMR_DIV1024_MASK;
            3'h6: timer_tick = ext_prev_q & ~ext_clk_pin;
            3'h7: timer_tick = ~ext_prev_q & ext_clk_pin;
            default: timer_tick = 1'b0;
        endcase
    end
endmodule // tmr_prescale

`default_nettype wire

// ### verilog/tmr_wavegen.v
`include "tmr_defs.vh"
`default_nettype none

module tmr_wavegen (
    input wire pclk,
    input wire presetn,
    input wire step,
    input wire force_now,
    input wire [1:0] waveform_mode_field,
    input wire [1:0] output_mode_field,
    input wire match,
    input wire at_max,
    input wire at_bottom,
    input wire dir_up,
    input wire cmp_is_max,
    output reg compare_output
);
    reg seen_up_q;
    reg out_d;
    reg seen_d;

    // level produced by a match, given the slope it happens on
    function match_level;
        input [1:0] om;
        input up;
        input cur;
        begin
            case (om)
                `TMR_OM_TOGGLE: match_level = ~cur;
                `TMR_OM_CLEAR: match_level = ~up;
                `TMR_OM_SET: match_level = up;
                default: match_level = cur;
            endcase
        end
    endfunction

    // next output level per waveform mode
    always @* begin
        out_d = compare_output;
        seen_d = seen_up_q;
        case (waveform_mode_field)
            `TMR_WM_FAST: begin
                if (at_max && output_mode_field[1])
                    out_d = ~output_mode_field[0]; // wrap wins over match at max
                else if (match)
                    out_d = match_level(output_mode_field, 1'b1, compare_output);
            end
            `TMR_WM_PHASE: begin
                if (at_max && cmp_is_max && output_mode_field[1])
                    out_d = ~output_mode_field[0]; // match ignored, down result at top
                else if (at_bottom) begin
                    // bottom is the turn point: act as up match when missed
                    if ((match || !seen_up_q) && !cmp_is_max && output_mode_field[1])
                        out_d = output_mode_field[0];
                    seen_d = 1'b0;
                end else if (match && output_mode_field[1]) begin
                    out_d = match_level(output_mode_field, dir_up, compare_output);
                    if (dir_up)
                        seen_d = 1'b1;
                end
            end
            default: begin
                if (match)
                    out_d = match_level(output_mode_field, 1'b1, compare_output);
            end
        endcase
    end

    // output state register; force strobe only exists in non-PWM modes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_output <= 1'b0;
            seen_up_q <= 1'b0;
        end else if (force_now && !waveform_mode_field[0]) begin
            compare_output <= match_level(output_mode_field, 1'b1, compare_output);
        end else if (step) begin
            compare_output <= out_d;
            seen_up_q <= seen_d;
        end
    end
endmodule // tmr_wavegen

`default_nettype wire

// ### verilog/tmr_top.v
// Our own choices: the address map and the APB slave port.
`include "tmr_defs.vh"
`default_nettype none

module tmr_top (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    input wire ext_clk_pin,
    output wire compare_output_pin,
    output wire compare_output_oe
);
    // control fields
    reg [1:0] waveform_mode_q;
    reg [1:0] output_mode_q;
    reg [2:0] clock_select_q;
    reg pin_dir_q;

    // counter and compare state
    reg [7:0] counter_value_q;
    reg [7:0] counter_value_d;
    reg dir_up_q;
    reg dir_up_d;
    reg [7:0] compare_value_q;
    reg [7:0] compare_buf_q;
    reg block_q;

    // flags
    reg overflow_flag_q;
    reg compare_flag_q;

    wire timer_tick;
    wire step;
    wire access;
    wire wr_en;
    wire rd_setup;
    wire hit_ctrl;
    wire hit_count;
    wire hit_cmp;
    wire hit_flags;
    wire mapped;
    wire count_wr;
    wire ctrl_wr;
    wire cmp_wr;
    wire flags_wr;
    wire pwm_mode;
    wire raw_match;
    wire match;
    wire at_max;
    wire at_bottom;
    wire ovf_event;
    wire cmp_update;
    wire force_now;
    wire compare_output;

    // a mode is PWM when the low waveform bit is set (modes 1 and 3)
    function is_pwm;
        input [1:0] wm;
        begin
            is_pwm = wm[0];
        end
    endfunction

    // address decode shared by read and write paths
    function [3:0] decode;
        input [11:0] a;
        begin
            decode[0] = a == `TMR_ADDR_CTRL;
            decode[1] = a == `TMR_ADDR_COUNT;
            decode[2] = a == `TMR_ADDR_CMP;
            decode[3] = a == `TMR_ADDR_FLAGS;
        end
    endfunction

    // tick generation from the clock selection
    tmr_prescale u_prescale (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .clock_select_field(clock_select_q),
        .ext_clk_pin(ext_clk_pin),
        .timer_tick(timer_tick)
    );

    // timer work happens on pclk only when the tick enable is present
    assign step = clk_en & timer_tick;

    // apb slave: zero wait states, error on unmapped address
    assign {hit_flags, hit_cmp, hit_count, hit_ctrl} = decode(paddr);
    assign mapped = hit_ctrl | hit_count | hit_cmp | hit_flags;
    assign access = psel & penable;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign wr_en = access & pwrite & clk_en;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign ctrl_wr = wr_en & hit_ctrl;
    assign count_wr = wr_en & hit_count;
    assign cmp_wr = wr_en & hit_cmp;
    assign flags_wr = wr_en & hit_flags;
    assign force_now = ctrl_wr & pwdata[`TMR_CTRL_FORCE];

    assign pwm_mode = is_pwm(waveform_mode_q);
    assign at_max = counter_value_q == `TMR_MAX;
    assign at_bottom = counter_value_q == `TMR_BOTTOM;

    // comparator, blocked for one tick after a counter write
    assign raw_match = counter_value_q == compare_value_q;
    assign match = raw_match & ~block_q;

    // double buffer reload: top in both PWM modes (phase correct is up at max)
    assign cmp_update = step & pwm_mode & at_max;

    // overflow event per waveform mode
    assign ovf_event = step & ((waveform_mode_q == `TMR_WM_PHASE) ?
        (at_bottom & ~dir_up_q) :
        at_max);

    // next counter value and direction; sequence depends on waveform mode and, in CTC, on the compare value
    always @* begin
        counter_value_d = counter_value_q + 8'h01;
        dir_up_d = 1'b1;
        case (waveform_mode_q)
            `TMR_WM_CTC: begin
                if (raw_match)
                    counter_value_d = `TMR_BOTTOM;
            end
            `TMR_WM_FAST: begin
                if (at_max)
                    counter_value_d = `TMR_BOTTOM;
            end
            `TMR_WM_PHASE: begin
                dir_up_d = dir_up_q;
                if (dir_up_q && at_max) begin
                    dir_up_d = 1'b0; // max seen for one tick then down
                    counter_value_d = `TMR_MAX - 8'h01;
                end else if (!dir_up_q && at_bottom) begin
                    dir_up_d = 1'b1;
                    counter_value_d = `TMR_BOTTOM + 8'h01;
                end else if (!dir_up_q) begin
                    counter_value_d = counter_value_q - 8'h01;
                end
            end
            default: begin
                counter_value_d = counter_value_q + 8'h01;
            end
        endcase
    end

    // counter register; software write has priority over count and clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value_q <= `TMR_BOTTOM;
            dir_up_q <= 1'b1;
        end else if (count_wr) begin
            counter_value_q <= pwdata[7:0];
        end else if (step) begin
            counter_value_q <= counter_value_d;
            dir_up_q <= dir_up_d;
        end
    end

    // match blocking lasts until the next tick, even while stopped
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            block_q <= 1'b0;
        else if (count_wr)
            block_q <= 1'b1;
        else if (step)
            block_q <= 1'b0;
    end

    // compare value and its buffer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_value_q <= 8'h00;
            compare_buf_q <= 8'h00;
        end else begin
            if (cmp_wr)
                compare_buf_q <= pwdata[7:0];
            if (cmp_wr && !pwm_mode)
                compare_value_q <= pwdata[7:0]; // direct in non-PWM
            else if (cmp_update)
                compare_value_q <= compare_buf_q;
        end
    end

    // control register; force bit is a strobe and never stored
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            waveform_mode_q <= `TMR_WM_NORMAL;
            output_mode_q <= `TMR_OM_OFF;
            clock_select_q <= 3'h0;
            pin_dir_q <= 1'b0;
        end else if (ctrl_wr) begin
            waveform_mode_q <= pwdata[`TMR_CTRL_WMODE_LO +: 2];
            output_mode_q <= pwdata[`TMR_CTRL_OMODE_LO +: 2];
            clock_select_q <= pwdata[`TMR_CTRL_CSEL_LO +: 3];
            pin_dir_q <= pwdata[`TMR_CTRL_PINDIR];
        end
    end

    // sticky flags: hardware sets, software clears by writing one; set wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_q <= 1'b0;
            compare_flag_q <= 1'b0;
        end else begin
            if (ovf_event)
                overflow_flag_q <= 1'b1;
            else if (flags_wr && pwdata[`TMR_FLAG_OVF])
                overflow_flag_q <= 1'b0;
            if (step && match)
                compare_flag_q <= 1'b1;
            else if (flags_wr && pwdata[`TMR_FLAG_CMP])
                compare_flag_q <= 1'b0;
        end
    end

    // output state machine of the waveform generator
    tmr_wavegen u_wavegen (
        .pclk(pclk),
        .presetn(presetn),
        .step(step),
        .force_now(force_now),
        // a forced match acts with the modes written beside the strobe
        .waveform_mode_field(force_now ? pwdata[`TMR_CTRL_WMODE_LO +: 2] : waveform_mode_q),
        .output_mode_field(force_now ? pwdata[`TMR_CTRL_OMODE_LO +: 2] : output_mode_q),
        .match(match),
        .at_max(at_max),
        .at_bottom(at_bottom),
        .dir_up(dir_up_q),
        .cmp_is_max(compare_value_q == `TMR_MAX),
        .compare_output(compare_output)
    );

    // pin override needs a non-zero output mode; the driver needs direction set
    assign compare_output_pin = compare_output;
    assign compare_output_oe = pin_dir_q & (output_mode_q != `TMR_OM_OFF);

    // read data captured in the setup phase so it stands through the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup && clk_en) begin
            prdata <= 32'h00000000;
            if (hit_ctrl)
                prdata <= {23'h000000, pin_dir_q, 1'b0, clock_select_q,
                           output_mode_q, waveform_mode_q};
            else if (hit_count)
                prdata <= {24'h000000, counter_value_q};
            else if (hit_cmp)
                prdata <= {24'h000000, compare_buf_q};
            else if (hit_flags)
                prdata <= {30'h00000000, compare_flag_q, overflow_flag_q};
        end
    end
endmodule // tmr_top

`default_nettype wire

// ### bench/tmr_port_model.sv
`default_nettype none
// port pad beyond the timer: the pin driver plus a weak pull-up
module tmr_port_model (
    input wire logic pin,
    input wire logic oe,
    output logic pad
);
    timeunit 1ns;
    timeprecision 1ns;
    // a released pad shows the pull-up, never the last driven level
    assign pad = oe ? pin : 1'h1;
endmodule // tmr_port_model
`default_nettype wire

// ### bench/tmr_top_properties.sv
`default_nettype none
module tmr_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic ext_clk_pin,
    input wire logic compare_output_pin,
    input wire logic compare_output_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] ctrl_q;
    logic [7:0] cnt_q;
    logic cnt_ok_q;
    // accepted access phase; clk_en low loses the transfer
    wire acc = psel && penable && clk_en;
    wire wr_ctrl = acc && pwrite && paddr == 12'h000;
    wire wr_cnt = acc && pwrite && paddr == 12'h004;
    // shadow of control, and a parked count that is only known while nothing ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 9'h000;
            cnt_q <= 8'h00;
            cnt_ok_q <= 1'h1;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[8:0] & 9'h17F; // force bit is a strobe
            end
            if (wr_cnt) begin
                cnt_q <= pwdata[7:0];
                cnt_ok_q <= ctrl_q[6:4] == 3'h0;
            end else if (ctrl_q[6:4] != 3'h0) begin
                cnt_ok_q <= 1'h0;
            end
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // software force in a non-pwm mode while the timer is stopped
    sequence s_force(logic [1:0] om);
        wr_ctrl && !pwdata[0] && pwdata[7] && pwdata[6:4] == 3'h0 && ctrl_q[6:4] == 3'h0
            && pwdata[3:2] == om;
    endsequence
    a_force_off: assert property (
        s_force(2'h0) |=> $stable(compare_output_pin))
        else $error("force with mode zero moved the output");
    a_force_toggle: assert property (
        s_force(2'h1) |=> compare_output_pin != $past(compare_output_pin))
        else $error("force did not toggle the output");
    a_force_clear: assert property (
        s_force(2'h2) |=> !compare_output_pin)
        else $error("force did not clear the output");
    a_force_set: assert property (
        s_force(2'h3) |=> compare_output_pin)
        else $error("force did not set the output");
    a_oe_source: assert property (
        compare_output_oe == (ctrl_q[8] && ctrl_q[3:2] != 2'h0))
        else $error("output enable not from pin direction and mode");
    a_err_decode: assert property (
        acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h00C))
        else $error("error response wrong for address");
    a_count_held: assert property (
        acc && !pwrite && paddr == 12'h004 && cnt_ok_q |-> prdata[7:0] == cnt_q)
        else $error("stopped counter lost its written value");
    a_ctrl_read: assert property (
        acc && !pwrite && paddr == 12'h000 |-> prdata == {23'h0, ctrl_q})
        else $error("control read differs from last write");
    a_pin_quiet: assert property (
        $changed(compare_output_pin) |-> $past(wr_ctrl) || $past(ctrl_q[6:4]) != 3'h0
            || $past(ctrl_q[6:4], 2) != 3'h0)
        else $error("output moved with no tick and no force");
endmodule // tmr_chk
bind tmr_top tmr_chk tmr_chk_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .ext_clk_pin(ext_clk_pin),
    .compare_output_pin(compare_output_pin), .compare_output_oe(compare_output_oe));
`default_nettype wire

// ### bench/tb.sv
`include "tmr_defs.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 30000;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic clk_en = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, ext = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire logic pready, pslverr, pin, oe, pad;
    wire logic [31:0] prdata;
    logic [31:0] rdat;
    logic perr;
    int compares = 0;
    int n_mismatch = 0;
    int cyc = 0;
    int h;
    // force table: control word, expected state, expected pad
    logic [8:0] fw [5] = '{9'h18C, 9'h188, 9'h184, 9'h080, 9'h088};
    logic [4:0] fp = 5'h0D;
    logic [4:0] fd = 5'h1D;
    // pwm table: mode, compare, output mode, window, high cycles in window
    int pm [9] = '{3, 3, 3, 3, 3, 1, 1, 1, 1};
    int pc [9] = '{8'h40, 8'h40, 8'hFF, 8'h00, 8'h40, 8'h40, 8'h40, 8'h00, 8'hFF};
    int po [9] = '{2, 3, 2, 2, 1, 2, 3, 2, 2};
    int pw [9] = '{256, 256, 256, 256, 512, 510, 510, 510, 510};
    int pe [9] = '{65, 191, 256, 1, 256, 128, 382, 0, 510};

    always #25 pclk = ~pclk;

    tmr_top tmr_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .ext_clk_pin(ext),
        .compare_output_pin(pin), .compare_output_oe(oe));
    tmr_port_model tmr_port_model_i (.pin(pin), .oe(oe), .pad(pad));

    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
        xfer(1'h0, a, 32'h0);
        chk(nm, e, rdat);
    endtask

    // rising then falling edges on the external count input, spaced so each pulse gives one tick
    task automatic stp(input int n);
        repeat (n) begin
            ext <= 1'h1;
            repeat (4) @(posedge pclk);
            ext <= 1'h0;
            repeat (4) @(posedge pclk);
        end
    endtask

    // a hung handshake ends here; the pwm sweep alone needs about 13.6k cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        rc(`TMR_ADDR_CTRL, 32'h0, "ctrl");
        rc(`TMR_ADDR_COUNT, 32'h0, "count");
        rc(`TMR_ADDR_CMP, 32'h0, "compare");
        rc(`TMR_ADDR_FLAGS, 32'h0, "flags");
        rc(12'h010, 32'h0, "unmapped");
        chk("unmapped err", 32'h1, {31'h0, perr});
        chk("reset oe", 32'h0, {31'h0, oe});
        $display("test reset finished");
        wr(`TMR_ADDR_COUNT, 32'h55);
        clk_en <= 1'h0;
        wr(`TMR_ADDR_COUNT, 32'h77);
        clk_en <= 1'h1;
        repeat (20) @(posedge pclk);
        rc(`TMR_ADDR_COUNT, 32'h55, "stopped count");
        for (int i = 0; i < 5; i++) begin
            wr(`TMR_ADDR_CTRL, {23'h0, fw[i]});
            @(posedge pclk);
            chk("forced state", {31'h0, fp[i]}, {31'h0, pin});
            chk("pad", {31'h0, fd[i]}, {31'h0, pad});
        end
        rc(`TMR_ADDR_CTRL, 32'h008, "force reads zero");
        $display("test force finished");
        wr(`TMR_ADDR_COUNT, 32'hFE);
        wr(`TMR_ADDR_CTRL, 32'h070);
        stp(1);
        rc(`TMR_ADDR_COUNT, 32'hFF, "normal count");
        rc(`TMR_ADDR_FLAGS, 32'h0, "flags before wrap");
        stp(1);
        rc(`TMR_ADDR_COUNT, 32'h0, "normal wrap");
        rc(`TMR_ADDR_FLAGS, 32'h1, "overflow");
        wr(`TMR_ADDR_FLAGS, 32'h3);
        rc(`TMR_ADDR_FLAGS, 32'h0, "flags cleared");
        // falling external edges, then exactly 64 pclk edges of the divide-by-8 source
        wr(`TMR_ADDR_CTRL, 32'h060);
        stp(2);
        rc(`TMR_ADDR_COUNT, 32'h2, "falling ext");
        wr(`TMR_ADDR_CTRL, 32'h020);
        repeat (61) @(posedge pclk);
        wr(`TMR_ADDR_CTRL, 32'h000);
        rc(`TMR_ADDR_COUNT, 32'hA, "div8 count");
        $display("test normal finished");
        wr(`TMR_ADDR_CMP, 32'h3);
        wr(`TMR_ADDR_COUNT, 32'h0);
        wr(`TMR_ADDR_CTRL, 32'h176);
        stp(3);
        rc(`TMR_ADDR_COUNT, 32'h3, "ctc top");
        chk("ctc pad", 32'h0, {31'h0, pad});
        stp(1);
        rc(`TMR_ADDR_COUNT, 32'h0, "ctc clear");
        chk("ctc toggle", 32'h1, {31'h0, pad});
        rc(`TMR_ADDR_FLAGS, 32'h2, "compare flag");
        stp(4);
        chk("ctc toggle back", 32'h0, {31'h0, pad});
        wr(`TMR_ADDR_FLAGS, 32'h3);
        wr(`TMR_ADDR_COUNT, 32'h3);
        stp(1);
        rc(`TMR_ADDR_COUNT, 32'h0, "blocked clear");
        chk("blocked pad", 32'h0, {31'h0, pad});
        rc(`TMR_ADDR_FLAGS, 32'h0, "blocked flags");
        wr(`TMR_ADDR_COUNT, 32'h5);
        stp(1);
        rc(`TMR_ADDR_COUNT, 32'h6, "past top");
        wr(`TMR_ADDR_COUNT, 32'hFF);
        stp(1);
        rc(`TMR_ADDR_COUNT, 32'h0, "ctc wrap");
        rc(`TMR_ADDR_FLAGS, 32'h1, "ctc overflow");
        $display("test ctc finished");
        for (int i = 0; i < 9; i++) begin
            wr(`TMR_ADDR_CTRL, 32'h110 | (po[i] << 2) | pm[i]);
            wr(`TMR_ADDR_CMP, pc[i]);
            repeat (1100) @(posedge pclk);
            wr(`TMR_ADDR_FLAGS, 32'h3);
            h = 0;
            repeat (pw[i]) begin
                @(posedge pclk);
                h += pad;
            end
            chk("high cycles", pe[i], h);
            rc(`TMR_ADDR_FLAGS, 32'h3, "pwm flags");
        end
        $display("test pwm finished");
        conclude();
    end
endmodule // tb
`default_nettype wire
